// ===== core/rmef_pkg.sv
// Purpose: Shared constants and types for the radio event flag block
// Assumes: Register port is a byte-wide serial frame on the link clock
// Notes: Offsets are byte addresses on the serial register port
package rmef_pkg;

    // Register offsets
    localparam logic [6:0] TX_FLAGS_ADDR = 7'h05;
    localparam logic [6:0] RX_FLAGS_ADDR = 7'h06;
    localparam logic [6:0] SIG_FLAGS_ADDR = 7'h07;
    localparam logic [6:0] RDY_EN_ADDR = 7'h08;
    localparam logic [6:0] TX_EN_ADDR = 7'h09;
    localparam logic [6:0] RX_EN_ADDR = 7'h0A;
    localparam logic [6:0] SIG_EN_ADDR = 7'h0B;
    localparam logic [6:0] PIN_CTRL_ADDR = 7'h0C;
    localparam logic [6:0] PIN_CFG_ADDR = 7'h0D;
    localparam logic [6:0] BAT_THR_ADDR = 7'h3F;

    // Bits cleared by a read
    localparam logic [7:0] TX_RC_MASK = 8'hFE;
    localparam logic [7:0] RX_RC_MASK = 8'hEF;
    localparam logic [7:0] SIG_RC_MASK = 8'hC8;
    // Bits cleared by writing zero (not cleared by a read), then implemented enable bits
    localparam logic [7:0] TX_WZ_MASK = 8'h01;
    localparam logic [7:0] SIG_WZ_MASK = 8'h37;
    localparam logic [7:0] RX_IMPL_MASK = 8'hEF;
    localparam logic [7:0] RDY_EN_MASK = 8'h36;

    // Reset values
    localparam logic [7:0] SIG_EN_RESET = 8'h38;
    localparam logic [7:0] EN_RESET = 8'h00;
    localparam logic [4:0] BAT_THR_RESET = 5'h00;
    localparam logic [3:0] PIN_MODE_RESET = 4'h0;
    localparam logic PIN_GIE_RESET = 1'b1;

    // Field positions
    localparam int PIN_GIE_BIT = 6;
    localparam int PIN_PEND_BIT = 4;
    localparam int PIN_EN_BIT = 7;
    localparam logic [3:0] PIN_MODE_NORMAL = 4'h0;

    // Transmit buffer capacity in bytes (arbitrary default)
    localparam logic [7:0] TX_BUF_CAP = 8'h7F;

    // Stream timeout unit and derived cycle count at 250 MHz
    localparam int STREAM_TICK_NS = 1000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int STREAM_TICK_CYCLES = STREAM_TICK_NS / CLK_PERIOD_NS;

    // Serial frame
    localparam logic [4:0] ADDR_DONE_CNT = 5'h07;
    localparam logic [4:0] BYTE2_DONE_CNT = 5'h0F;
    localparam logic [4:0] DATA_OUT_CNT = 5'h10;

    typedef struct packed {
        logic tx_done;
        logic tx_is_auto_ack;
        logic tx_is_repeat;
        logic preamble_sent;
        logic ack_timeout;
        logic ack_requested;
        logic channel_busy;
        logic host_tx_write;
        logic parse_error;
        logic rx_frame_end;
        logic rx_filtered;
        logic rx_buffers_full;
        logic decrypt_done;
        logic decrypt_error;
        logic delimiter_sent;
        logic delimiter_found;
        logic malfunction;
        logic resistor_fault;
    } rmef_ev_t;

    typedef struct packed {
        logic transmit_start;
        logic encrypt_start;
        logic energy_detect_start;
        logic channel_check_start;
        logic carrier_sense_enable;
        logic tx_buffer_empty;
        logic stream_mode;
        logic [3:0] max_retry_count;
        logic [2:0] backoff_limit;
        logic [7:0] stream_timeout_value;
        logic [7:0] tx_length;
        logic [7:0] rx_seq;
        logic [15:0] rx_src;
        logic [4:0] supply_level;
    } rmef_lvl_t;

endpackage : rmef_pkg

// ===== core/rmef_top.sv
// Purpose: Event flags, enables and interrupt pin of the radio MAC
// Assumes: Event inputs run on ref_clk; serial port runs on spi_sck
// Notes: Reads need a dummy byte between address and data
//
// How it works
// - Host-started transmit success sets tx done, not auto-ack or repeat.
// - Encrypt-start falling back to zero sets encrypt-done flag.
// - First preamble sample on air sets medium-access flag.
// - Ack timeout after max retries with ack requested sets failure flag.
// - Channel busy backoff-limit times with carrier sense on sets flag.
// - On transmit start, zero or oversize length byte sets size-error flag.
// - Host write into a non-empty transmit buffer sets overflow flag.
// - Parser failure on a transmit or receive frame sets format-error flag.
// - Read-clear flags stay set until the host reads their register.
// - Accepted non-duplicate packet sets receive-success once.
// - Decrypt completion sets pass flag, or fail flag on error.
// - Sequence and source matching previous frame sets duplicate flag.
// - Packet rejected by a filter sets packet-filtered flag.
// - Packet arriving with all buffers full is dropped, overflow flag set.
// - Stream timeout after last packet sets flag, forgets stored sequence.
// - Last delimiter sample sent sets transmit delimiter flag.
// - Incoming frame delimiter detected sets receive delimiter flag.
// - Malfunction entry sets general error flag, not cleared by read.
// - Supply below battery threshold or resistor fault sets warning flag.
// - Measurement start bit cleared by device sets measurement-done flag.
// - Pin flag sets when normal mode, enabled, input, level matches polarity.
// - First enable register holds four enables; reserved bits stay zero.
// - Each enable masks its own flag from the request.
// - Pending request is the OR of all enabled flags.
// - Global enable drives pending request onto active-low interrupt pin.
`timescale 1ns/100ps
module rmef_top (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire rmef_pkg::rmef_ev_t ev,
    input wire rmef_pkg::rmef_lvl_t lvl,
    input wire logic [7:0] ready_flags,
    input wire logic [2:0] gpio_pin,
    output logic irq_n,
    output logic request_pending
);

    ////////////////////////////////////////////////////////////////////////
    // Link side: serial shift logic on spi_sck

    logic link_rst;
    logic [4:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] out_shift;
    logic req_tgl;
    logic req_wr;
    logic [6:0] req_addr;
    logic [7:0] req_data;
    logic ack_s1;
    logic ack_s2;
    logic ack_tgl;
    logic [7:0] rd_hold;
    logic rd_frame;

    // Frame ends with chip select; nothing counts on a clock outside it
    assign link_rst = sys_rst | spi_cs_n;

    always_ff @(posedge spi_sck or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt <= 5'h00;
            shift_in <= 8'h00;
            rd_frame <= 1'b0;
        end else begin
            if (bit_cnt != 5'h1F) begin
                bit_cnt <= bit_cnt + 5'h01;
            end
            shift_in <= {shift_in[6:0], spi_mosi};
            if (bit_cnt == rmef_pkg::ADDR_DONE_CNT) begin
                rd_frame <= shift_in[6];
            end
        end
    end

    // Request toggle outlives the frame, so only system reset clears it
    always_ff @(posedge spi_sck or posedge sys_rst) begin
        if (sys_rst) begin
            req_tgl <= 1'b0;
            req_wr <= 1'b0;
            req_addr <= 7'h00;
            req_data <= 8'h00;
        end else if (!spi_cs_n) begin
            if (bit_cnt == rmef_pkg::ADDR_DONE_CNT && shift_in[6]) begin
                req_tgl <= ~req_tgl;
                req_wr <= 1'b0;
                req_addr <= {shift_in[5:0], spi_mosi};
            end else if (bit_cnt == rmef_pkg::ADDR_DONE_CNT) begin
                req_addr <= {shift_in[5:0], spi_mosi};
            end else if (bit_cnt == rmef_pkg::BYTE2_DONE_CNT && !rd_frame) begin
                req_tgl <= ~req_tgl;
                req_wr <= 1'b1;
                req_data <= {shift_in[6:0], spi_mosi};
            end
        end
    end

    always_ff @(posedge spi_sck or posedge sys_rst) begin
        if (sys_rst) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
        end
    end

    // Hold register is stable once the answer toggle has come back
    always_ff @(posedge spi_sck or posedge link_rst) begin
        if (link_rst) begin
            out_shift <= 8'h00;
        end else if (bit_cnt == rmef_pkg::BYTE2_DONE_CNT && rd_frame) begin
            out_shift <= (ack_s2 == req_tgl) ? rd_hold : 8'h00;
        end
    end

    always_ff @(negedge spi_sck or posedge link_rst) begin
        if (link_rst) begin
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else begin
            spi_miso_oe <= rd_frame && bit_cnt >= rmef_pkg::DATA_OUT_CNT;
            if (bit_cnt >= rmef_pkg::DATA_OUT_CNT && bit_cnt < 5'h18) begin
                spi_miso <= out_shift[3'(5'h17 - bit_cnt)];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Crossing into the system clock

    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic req_seen;
    logic host_rd;
    logic host_wr;
    logic [2:0] gpio_s1;
    logic [2:0] gpio_s2;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
            gpio_s1 <= 3'h0;
            gpio_s2 <= 3'h0;
        end else begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            gpio_s1 <= gpio_pin;
            gpio_s2 <= gpio_s1;
        end
    end

    assign req_seen = req_s2 ^ req_s3;
    assign host_rd = req_seen && !req_wr;
    assign host_wr = req_seen && req_wr;

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers

    logic [7:0] tx_en;
    logic [7:0] rx_en;
    logic [7:0] sig_en;
    logic [7:0] rdy_en;
    logic global_irq_enable;
    logic [3:0] pin_function_select;
    logic [7:0] pin_cfg;
    logic [4:0] battery_threshold;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_en <= rmef_pkg::EN_RESET;
            rx_en <= rmef_pkg::EN_RESET;
            sig_en <= rmef_pkg::SIG_EN_RESET;
            rdy_en <= rmef_pkg::EN_RESET;
            global_irq_enable <= rmef_pkg::PIN_GIE_RESET;
            pin_function_select <= rmef_pkg::PIN_MODE_RESET;
            pin_cfg <= rmef_pkg::EN_RESET;
            battery_threshold <= rmef_pkg::BAT_THR_RESET;
        end else if (host_wr) begin
            unique case (req_addr)
                rmef_pkg::TX_EN_ADDR: tx_en <= req_data;
                rmef_pkg::RX_EN_ADDR: rx_en <= req_data & rmef_pkg::RX_IMPL_MASK;
                rmef_pkg::SIG_EN_ADDR: sig_en <= req_data;
                rmef_pkg::RDY_EN_ADDR: rdy_en <= req_data & rmef_pkg::RDY_EN_MASK;
                rmef_pkg::PIN_CTRL_ADDR: begin
                    global_irq_enable <= req_data[rmef_pkg::PIN_GIE_BIT];
                    pin_function_select <= req_data[3:0];
                end
                rmef_pkg::PIN_CFG_ADDR: pin_cfg <= req_data;
                rmef_pkg::BAT_THR_ADDR: battery_threshold <= req_data[4:0];
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event qualification

    logic enc_q;
    logic ed_q;
    logic cca_q;
    logic transmit_start_q;
    logic size_chk;
    logic mal_q;
    logic low_q;
    logic [3:0] retry_cnt;
    logic [2:0] busy_cnt;
    logic prev_valid;
    logic [7:0] prev_seq;
    logic [15:0] prev_src;
    logic is_dup;
    logic stream_armed;
    logic [7:0] tick_cnt;
    logic [7:0] unit_cnt;
    logic stream_fire;
    logic supply_low;
    logic [2:0] pin_hit;

    assign is_dup = prev_valid && lvl.rx_seq == prev_seq && lvl.rx_src == prev_src;
    assign supply_low = lvl.supply_level < battery_threshold;
    assign stream_fire = stream_armed && lvl.stream_mode
        && unit_cnt == 8'(rmef_pkg::STREAM_TICK_CYCLES - 1)
        && tick_cnt + 8'h01 >= lvl.stream_timeout_value;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            enc_q <= 1'b0;
            ed_q <= 1'b0;
            cca_q <= 1'b0;
            transmit_start_q <= 1'b0;
            size_chk <= 1'b0;
            mal_q <= 1'b0;
            low_q <= 1'b0;
        end else begin
            enc_q <= lvl.encrypt_start;
            ed_q <= lvl.energy_detect_start;
            cca_q <= lvl.channel_check_start;
            transmit_start_q <= lvl.transmit_start;
            size_chk <= lvl.transmit_start && !transmit_start_q;
            mal_q <= ev.malfunction;
            low_q <= supply_low;
        end
    end

    // Attempt counters restart with each host transmit start
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            retry_cnt <= 4'h0;
            busy_cnt <= 3'h0;
        end else if (lvl.transmit_start && !transmit_start_q) begin
            retry_cnt <= 4'h0;
            busy_cnt <= 3'h0;
        end else begin
            if (ev.ack_timeout && retry_cnt != 4'hF) begin
                retry_cnt <= retry_cnt + 4'h1;
            end
            if (ev.channel_busy && lvl.carrier_sense_enable && busy_cnt != 3'h7) begin
                busy_cnt <= busy_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_valid <= 1'b0;
            prev_seq <= 8'h00;
            prev_src <= 16'h0000;
        end else if (stream_fire) begin
            prev_valid <= 1'b0;
            prev_seq <= 8'h00;
        end else if (ev.rx_frame_end && !ev.rx_buffers_full && !ev.rx_filtered) begin
            prev_valid <= 1'b1;
            prev_seq <= lvl.rx_seq;
            prev_src <= lvl.rx_src;
        end
    end

    // Timeout counts whole ticks since the last packet, once per packet
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stream_armed <= 1'b0;
            tick_cnt <= 8'h00;
            unit_cnt <= 8'h00;
        end else if (ev.rx_frame_end) begin
            stream_armed <= 1'b1;
            tick_cnt <= 8'h00;
            unit_cnt <= 8'h00;
        end else if (stream_fire) begin
            stream_armed <= 1'b0;
        end else if (stream_armed) begin
            if (unit_cnt == 8'(rmef_pkg::STREAM_TICK_CYCLES - 1)) begin
                unit_cnt <= 8'h00;
                tick_cnt <= tick_cnt + 8'h01;
            end else begin
                unit_cnt <= unit_cnt + 8'h01;
            end
        end
    end

    // Pin input mode is bits 6:4, polarity bits 2:0
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_hit[i] = pin_function_select == rmef_pkg::PIN_MODE_NORMAL
                && pin_cfg[rmef_pkg::PIN_EN_BIT] && pin_cfg[4 + i]
                && gpio_s2[i] == pin_cfg[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag registers

    logic [7:0] tx_flags;
    logic [7:0] rx_flags;
    logic [7:0] sig_flags;
    logic [7:0] tx_set;
    logic [7:0] rx_set;
    logic [7:0] sig_set;
    logic [7:0] tx_clr;
    logic [7:0] rx_clr;
    logic [7:0] sig_clr;
    logic rx_ok;

    assign rx_ok = ev.rx_frame_end && !ev.rx_buffers_full && !ev.rx_filtered;

    always_comb begin
        tx_set[7] = ev.tx_done && !ev.tx_is_auto_ack && !ev.tx_is_repeat;
        tx_set[6] = enc_q && !lvl.encrypt_start;
        tx_set[5] = ev.preamble_sent;
        tx_set[4] = ev.ack_timeout && ev.ack_requested && retry_cnt == lvl.max_retry_count;
        tx_set[3] = ev.channel_busy && lvl.carrier_sense_enable
            && busy_cnt + 3'h1 == lvl.backoff_limit;
        tx_set[2] = size_chk && (lvl.tx_length == 8'h00 || lvl.tx_length > rmef_pkg::TX_BUF_CAP);
        tx_set[1] = ev.host_tx_write && !lvl.tx_buffer_empty;
        tx_set[0] = ev.parse_error;
        rx_set[7] = rx_ok && !is_dup;
        rx_set[6] = ev.decrypt_done && !ev.decrypt_error;
        rx_set[5] = ev.decrypt_done && ev.decrypt_error;
        rx_set[4] = 1'b0;
        rx_set[3] = rx_ok && is_dup;
        rx_set[2] = ev.rx_frame_end && !ev.rx_buffers_full && ev.rx_filtered;
        rx_set[1] = ev.rx_frame_end && ev.rx_buffers_full;
        rx_set[0] = stream_fire;
        sig_set[7] = ev.delimiter_sent;
        sig_set[6] = ev.delimiter_found;
        sig_set[5] = ev.malfunction && !mal_q;
        sig_set[4] = (supply_low && !low_q) || ev.resistor_fault;
        sig_set[3] = (ed_q && !lvl.energy_detect_start) || (cca_q && !lvl.channel_check_start);
        sig_set[2:0] = pin_hit;
    end

    always_comb begin
        tx_clr = 8'h00;
        rx_clr = 8'h00;
        sig_clr = 8'h00;
        if (host_rd && req_addr == rmef_pkg::TX_FLAGS_ADDR) tx_clr = rmef_pkg::TX_RC_MASK;
        if (host_rd && req_addr == rmef_pkg::RX_FLAGS_ADDR) rx_clr = rmef_pkg::RX_RC_MASK;
        if (host_rd && req_addr == rmef_pkg::SIG_FLAGS_ADDR) sig_clr = rmef_pkg::SIG_RC_MASK;
        if (host_wr && req_addr == rmef_pkg::TX_FLAGS_ADDR) tx_clr = ~req_data & rmef_pkg::TX_WZ_MASK;
        if (host_wr && req_addr == rmef_pkg::SIG_FLAGS_ADDR) begin
            sig_clr = ~req_data & rmef_pkg::SIG_WZ_MASK;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_flags <= 8'h00;
            rx_flags <= 8'h00;
            sig_flags <= 8'h00;
        end else begin
            tx_flags <= (tx_flags & ~tx_clr) | tx_set;
            rx_flags <= (rx_flags & ~rx_clr) | rx_set;
            sig_flags <= (sig_flags & ~sig_clr) | sig_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read answer and interrupt pin

    logic next_pending;
    logic [7:0] rd_value;

    assign next_pending = |(tx_flags & tx_en) | |(rx_flags & rx_en)
        | |(sig_flags & sig_en) | |(ready_flags & rdy_en);

    always_comb begin
        unique case (req_addr)
            rmef_pkg::TX_FLAGS_ADDR: rd_value = tx_flags;
            rmef_pkg::RX_FLAGS_ADDR: rd_value = rx_flags;
            rmef_pkg::SIG_FLAGS_ADDR: rd_value = sig_flags;
            rmef_pkg::RDY_EN_ADDR: rd_value = rdy_en;
            rmef_pkg::TX_EN_ADDR: rd_value = tx_en;
            rmef_pkg::RX_EN_ADDR: rd_value = rx_en;
            rmef_pkg::SIG_EN_ADDR: rd_value = sig_en;
            rmef_pkg::PIN_CTRL_ADDR: rd_value = {1'b0, global_irq_enable, 1'b0,
                request_pending, pin_function_select};
            rmef_pkg::PIN_CFG_ADDR: rd_value = pin_cfg;
            rmef_pkg::BAT_THR_ADDR: rd_value = {3'h0, battery_threshold};
            default: rd_value = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_hold <= 8'h00;
            ack_tgl <= 1'b0;
        end else if (req_seen) begin
            ack_tgl <= ~ack_tgl;
            if (!req_wr) rd_hold <= rd_value;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            request_pending <= 1'b0;
            irq_n <= 1'b1;
        end else begin
            request_pending <= next_pending;
            irq_n <= !(global_irq_enable && request_pending);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_tx_start;
        lvl.transmit_start && !transmit_start_q;
    endsequence

    sequence s_bad_len;
        lvl.tx_length == 8'h00 || lvl.tx_length > rmef_pkg::TX_BUF_CAP;
    endsequence

    a_size_error_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_tx_start ##1 s_bad_len |=> tx_flags[2])
        else $error("size error flag not set");

    a_auto_ack_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !tx_flags[7] && !tx_set[7] && ev.tx_done && ev.tx_is_auto_ack |=> !tx_flags[7])
        else $error("tx done set by auto ack");

    a_read_clears_rx: assert property (@(posedge ref_clk) disable iff (sys_rst)
        host_rd && req_addr == rmef_pkg::RX_FLAGS_ADDR && rx_set == 8'h00 |=> rx_flags == 8'h00)
        else $error("rx flags not cleared by read");

    a_set_beats_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
        host_rd && req_addr == rmef_pkg::TX_FLAGS_ADDR && ev.preamble_sent |=> tx_flags[5])
        else $error("event lost on read");

    a_error_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst)
        sig_flags[5] && host_rd |=> sig_flags[5])
        else $error("error flag cleared by read");

    a_dup_not_success: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rx_ok && is_dup && !rx_flags[7] |=> !rx_flags[7] && rx_flags[3])
        else $error("duplicate counted as success");

    a_overflow_drop: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ev.rx_frame_end && ev.rx_buffers_full && !rx_flags[7] |=> rx_flags[1] && !rx_flags[7])
        else $error("overflow not flagged");

    a_irq_pin_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
        next_pending && global_irq_enable ##1 global_irq_enable |=> !irq_n)
        else $error("interrupt pin not asserted");

    a_masked_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (tx_flags & tx_en) == 8'h00 && (rx_flags & rx_en) == 8'h00
        && (sig_flags & sig_en) == 8'h00 && (ready_flags & rdy_en) == 8'h00
        |=> !request_pending)
        else $error("masked flag raised request");

    a_enable_reserved: assert property (@(posedge ref_clk) disable iff (sys_rst)
        host_wr && req_addr == rmef_pkg::RDY_EN_ADDR |=> (rdy_en & ~rmef_pkg::RDY_EN_MASK) == 8'h00)
        else $error("reserved enable bit stored");

endmodule : rmef_top

// ===== bench/rmef_host.sv
// Purpose: Host side of the serial register port
// Assumes: Mode 0 framing, 125 ns link clock, idle low
// Notes: Clock stands still between frames
`timescale 1ns/100ps
module rmef_host (
    output logic sck,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // Address, data or dummy, then read data sampled on rising edges
    task xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            mosi = {a, d, 8'h00} >> i;
            #62.5;
            sck = 1'b1;
            if (i < 8) q[i] = miso;
            #62.5;
            sck = 1'b0;
        end
        cs_n = 1'b1;
        // Released line must not keep the last bit
        mosi = ~mosi;
        #125;
    endtask : xfer
endmodule : rmef_host

// ===== bench/testbench.sv
// Purpose: Self-checking bench for the event flag block
// Assumes: Inputs driven on the falling edge of ref_clk
// Notes: Waits after events follow the three-cycle pipeline
`timescale 1ns/100ps
module testbench;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, irq_n, request_pending;
    rmef_pkg::rmef_ev_t ev = '0;
    rmef_pkg::rmef_lvl_t lvl = '0;
    rmef_pkg::rmef_ev_t e;
    logic [7:0] q;
    logic [7:0] ready_flags = 8'h00;
    logic [2:0] gpio_pin = 3'h0;
    logic oe_seen;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;
    always #2 ref_clk = ~ref_clk;
    rmef_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .ev(ev), .lvl(lvl),
        .ready_flags(ready_flags), .gpio_pin(gpio_pin), .irq_n(irq_n),
        .request_pending(request_pending));
    rmef_host host (.sck(spi_sck), .cs_n(spi_cs_n), .mosi(spi_mosi), .miso(spi_miso));
    // Output enable as seen at the last link edge of a frame
    always @(posedge spi_sck) oe_seen <= spi_miso_oe;
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task rd(input logic [6:0] a, input logic [7:0] exp);
        host.xfer({1'b1, a}, 8'h00, q);
        chk(q, exp);
        chk({6'h0, oe_seen, spi_miso_oe}, 8'h02);
    endtask : rd
    task pulse();
        @(negedge ref_clk) ev = e;
        @(negedge ref_clk) ev = '0;
        repeat (5) @(negedge ref_clk);
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////////////
    task test_regs();
        rd(rmef_pkg::RDY_EN_ADDR, 8'h00);
        rd(rmef_pkg::SIG_EN_ADDR, 8'h38);
        host.xfer({1'b0, rmef_pkg::RDY_EN_ADDR}, 8'h36, q);
        rd(rmef_pkg::RDY_EN_ADDR, 8'h36);
        @(negedge ref_clk) ready_flags = 8'h20;
        repeat (3) @(negedge ref_clk);
        chk({6'h0, request_pending, irq_n}, 8'h02);
        ready_flags = 8'h01;
        repeat (3) @(negedge ref_clk);
        chk({6'h0, request_pending, irq_n}, 8'h01);
        ready_flags = 8'h00;
    endtask : test_regs
    task test_tx();
        e = '0;
        e.tx_done = 1'b1;
        e.tx_is_auto_ack = 1'b1;
        pulse();
        rd(rmef_pkg::TX_FLAGS_ADDR, 8'h00);
        e.tx_is_auto_ack = 1'b0;
        pulse();
        chk({6'h0, request_pending, irq_n}, 8'h01);
        rd(rmef_pkg::TX_FLAGS_ADDR, 8'h80);
        rd(rmef_pkg::TX_FLAGS_ADDR, 8'h00);
        @(negedge ref_clk) lvl.tx_length = 8'h80;
        lvl.transmit_start = 1'b1;
        repeat (4) @(negedge ref_clk);
        rd(rmef_pkg::TX_FLAGS_ADDR, 8'h04);
    endtask : test_tx
    task test_rx();
        @(negedge ref_clk) lvl.rx_seq = 8'h01;
        e = '0;
        e.rx_frame_end = 1'b1;
        e.rx_filtered = 1'b1;
        pulse();
        rd(rmef_pkg::RX_FLAGS_ADDR, 8'h04);
        e.rx_filtered = 1'b0;
        pulse();
        rd(rmef_pkg::RX_FLAGS_ADDR, 8'h80);
        pulse();
        rd(rmef_pkg::RX_FLAGS_ADDR, 8'h08);
        e.rx_buffers_full = 1'b1;
        pulse();
        rd(rmef_pkg::RX_FLAGS_ADDR, 8'h02);
        e.rx_buffers_full = 1'b0;
        e.rx_filtered = 1'b1;
        pulse();
        // Mode raised after the rearm, so an old timer cannot fire early
        lvl.stream_mode = 1'b1;
        repeat (300) @(negedge ref_clk);
        rd(rmef_pkg::RX_FLAGS_ADDR, 8'h05);
        @(negedge ref_clk) lvl.stream_mode = 1'b0;
        e.rx_filtered = 1'b0;
        pulse();
        rd(rmef_pkg::RX_FLAGS_ADDR, 8'h80);
    endtask : test_rx
    task test_irq();
        host.xfer({1'b0, rmef_pkg::TX_EN_ADDR}, 8'h80, q);
        e = '0;
        e.tx_done = 1'b1;
        pulse();
        chk({6'h0, request_pending, irq_n}, 8'h02);
        rd(rmef_pkg::TX_FLAGS_ADDR, 8'h80);
        repeat (5) @(negedge ref_clk);
        chk({6'h0, request_pending, irq_n}, 8'h01);
    endtask : test_irq
    task test_err();
        @(negedge ref_clk) ev.malfunction = 1'b1;
        rd(rmef_pkg::SIG_FLAGS_ADDR, 8'h20);
        rd(rmef_pkg::SIG_FLAGS_ADDR, 8'h20);
    endtask : test_err
    task test_race();
        @(negedge ref_clk) ev.preamble_sent = 1'b1;
        rd(rmef_pkg::TX_FLAGS_ADDR, 8'h20);
        @(negedge ref_clk) ev.preamble_sent = 1'b0;
        rd(rmef_pkg::TX_FLAGS_ADDR, 8'h20);
        rd(rmef_pkg::TX_FLAGS_ADDR, 8'h00);
    endtask : test_race
    task test_pin();
        // Pin 2 matches its polarity but is no input, pin 1 is no input
        host.xfer({1'b0, rmef_pkg::PIN_CFG_ADDR}, 8'h91, q);
        @(negedge ref_clk) gpio_pin = 3'h3;
        repeat (4) @(negedge ref_clk);
        rd(rmef_pkg::SIG_FLAGS_ADDR, 8'h21);
    endtask : test_pin
    ////////////////////////////////////////////////////////////////////////////////
    task close_out();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    // Ceiling about twice the length of the run
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        repeat (12) @(negedge ref_clk);
        sys_rst = 1'b0;
        test_regs();
        test_tx();
        test_rx();
        test_irq();
        test_race();
        test_err();
        test_pin();
        close_out();
    end
endmodule : testbench
